// file: hw/crosspoint_parallel_load.sv
`timescale 1ns/100ps
`include "xpt_consts.svh"
module crosspoint_parallel_load
	import xpt_pkg::*;
(
	// System.
	input  wire logic                                           clk,
	input  wire logic                                           rst,
	// Programming pins, asynchronous to clk.
	input  wire prog_pins_t                                     pins,
	// Device reset pin, active low, asynchronous.
	input  wire logic                                           reset_pin_n,
	// Switch matrix drive and daisy-chain output.
	output logic [`XPT_NUM_OUTPUTS-1:0][`XPT_NUM_INPUTS-1:0]    matrix_onehot,
	output route_word_t [`XPT_NUM_OUTPUTS-1:0]                  applied,
	output logic                                                serial_out
);

	prog_pins_t  pins_meta;
	prog_pins_t  pins_sync;
	logic        reset_meta;
	logic        reset_sync_n;
	logic        clk_prev;
	route_word_t first_rank [`XPT_NUM_OUTPUTS];
	route_word_t second_rank [`XPT_NUM_OUTPUTS];
	logic        capture_level;
	logic        shift_edge;
	logic        transparent;

	function automatic logic [`XPT_NUM_INPUTS-1:0] decode_route(input route_word_t w);
		logic [`XPT_NUM_INPUTS-1:0] v;
		v = '0;
		if (w.output_enable_bit) begin
			v[w.input_select] = 1'b1;
		end
		return v;
	endfunction

	// Pins pass two flip-flops before any logic looks at them.
	always_ff @(posedge clk) begin
		pins_meta    <= pins;
		pins_sync    <= pins_meta;
		reset_meta   <= reset_pin_n;
		reset_sync_n <= reset_meta;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			clk_prev <= 1'b1;
		end else begin
			clk_prev <= pins_sync.prog_clk;
		end
	end

	// Parallel mode latches while clock low; serial mode shifts on falling edge.
	assign capture_level = pins_sync.interface_select && !pins_sync.chip_select_n
		&& !pins_sync.prog_clk;
	assign shift_edge = !pins_sync.interface_select && !pins_sync.chip_select_n
		&& clk_prev && !pins_sync.prog_clk;
	assign transparent = !pins_sync.chip_select_n && !pins_sync.update_n;

	// First rank has no reset, so it holds arbitrary power-up contents.
	always_ff @(posedge clk) begin
		if (capture_level) begin
			first_rank[pins_sync.output_addr] <= pins_sync.data;
		end else if (shift_edge) begin
			for (int i = `XPT_NUM_OUTPUTS - 1; i > 0; i--) begin
				first_rank[i] <= {first_rank[i][`XPT_WORD_W-2:0], first_rank[i-1][`XPT_WORD_W-1]};
			end
			first_rank[0] <= {first_rank[0][`XPT_WORD_W-2:0], pins_sync.serial_in};
		end
	end

	genvar g;
	generate
		for (g = 0; g < `XPT_NUM_OUTPUTS; g++) begin : g_out
			always_ff @(posedge clk) begin
				if (rst || !reset_sync_n) begin
					second_rank[g] <= '0;
				end else if (transparent) begin
					second_rank[g] <= first_rank[g];
				end
			end
			always_ff @(posedge clk) begin
				if (rst) begin
					matrix_onehot[g] <= '0;
					applied[g]       <= '0;
				end else begin
					matrix_onehot[g] <= decode_route(second_rank[g]);
					applied[g]       <= second_rank[g];
				end
			end
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (rst) begin
			serial_out <= 1'b0;
		end else begin
			serial_out <= first_rank[`XPT_NUM_OUTPUTS-1][`XPT_WORD_W-1];
		end
	end

	// Checks watch one or two sample outputs, the two reset checks all of matrix_onehot; all eight share the same logic.
	AST_RESET_DISABLES: assert property (@(posedge clk) disable iff (rst)
		!reset_sync_n |=> ##2 (matrix_onehot == '0))
		else $error("outputs not disabled under reset");
	AST_HOLD_NO_UPDATE: assert property (@(posedge clk) disable iff (rst)
		(pins_sync.update_n && $past(pins_sync.update_n) && reset_sync_n && $past(reset_sync_n))
		|=> $stable(second_rank[0]))
		else $error("second rank changed without update");
	AST_TRANSFER: assert property (@(posedge clk) disable iff (rst)
		(transparent && reset_sync_n) |=> (second_rank[0] == $past(first_rank[0])))
		else $error("second rank not transparent");
	sequence s_load;
		capture_level && pins_sync.output_addr == 3'h2;
	endsequence
	AST_LOAD: assert property (@(posedge clk) disable iff (rst)
		s_load |=> (first_rank[2] == $past(pins_sync.data)))
		else $error("parallel capture missed");
	AST_OTHERS_KEPT: assert property (@(posedge clk) disable iff (rst)
		(capture_level && pins_sync.output_addr != 3'h0) |=> $stable(first_rank[0]))
		else $error("other output disturbed");
	AST_DISABLED_NONE: assert property (@(posedge clk) disable iff (rst)
		!second_rank[1].output_enable_bit |=> (matrix_onehot[1] == '0))
		else $error("disabled output drives");
	AST_ONEHOT: assert property (@(posedge clk) disable iff (rst)
		second_rank[3].output_enable_bit |=> $onehot(matrix_onehot[3]))
		else $error("decoder not one-hot");
	AST_INDEX: assert property (@(posedge clk) disable iff (rst)
		second_rank[4].output_enable_bit
		|=> matrix_onehot[4][$past(second_rank[4].input_select)])
		else $error("wrong input selected");
	AST_RESET_KEEPS_FIRST: assert property (@(posedge clk) disable iff (rst)
		(!reset_sync_n && !capture_level && !shift_edge) |=> $stable(first_rank[5]))
		else $error("reset touched first rank");

	// Each falling clock in serial mode moves the chain one place towards serial_out.
	sequence s_shift;
		shift_edge;
	endsequence

	AST_SHIFT_IN: assert property (@(posedge clk) disable iff (rst)
		s_shift |=> (first_rank[0][`XPT_SEL_LSB] == $past(pins_sync.serial_in)))
		else $error("serial bit not taken in");

	AST_SHIFT_CARRY: assert property (@(posedge clk) disable iff (rst)
		s_shift |=> (first_rank[4][`XPT_SEL_LSB] == $past(first_rank[3][`XPT_EN_POS])))
		else $error("serial chain broken between words");

	AST_SERIAL_OUT: assert property (@(posedge clk) disable iff (rst)
		s_shift |=> ##1 (serial_out == $past(first_rank[7][`XPT_SEL_MSB], 2)))
		else $error("serial output lags the chain");

	// The reset pin empties the second rank one edge after its synchronised level goes low.
	sequence s_pin_reset;
		!reset_sync_n;
	endsequence

	AST_PIN_CLEARS: assert property (@(posedge clk) disable iff (rst)
		s_pin_reset |=> (second_rank[6] == '0))
		else $error("second rank survived reset pin");

	AST_RST_DISABLES: assert property (@(posedge clk)
		rst |=> (matrix_onehot == '0))
		else $error("outputs not disabled by block reset");

	// Chip select and update both low, with the reset pin released, open the second rank.
	sequence s_update_open;
		transparent && reset_sync_n;
	endsequence

	AST_APPLY_WORD: assert property (@(posedge clk) disable iff (rst)
		s_update_open |=> ##1 (applied[7] == $past(first_rank[7], 2)))
		else $error("first rank not passed to outputs");

	AST_APPLY_MATRIX: assert property (@(posedge clk) disable iff (rst)
		s_update_open |=> ##1 (matrix_onehot[6] == decode_route($past(first_rank[6], 2))))
		else $error("pending setting not applied with the others");

	AST_RESUME: assert property (@(posedge clk) disable iff (rst)
		s_update_open |=> (second_rank[3] == $past(first_rank[3])))
		else $error("programming not resumed after reset");

	sequence s_load_six;
		capture_level && pins_sync.output_addr == 3'h6;
	endsequence

	AST_LEVEL_CAPTURE: assert property (@(posedge clk) disable iff (rst)
		s_load_six |=> (first_rank[6] == $past(pins_sync.data)))
		else $error("clock-low level did not capture");

	AST_SELECT_MATCH: assert property (@(posedge clk) disable iff (rst)
		second_rank[5].output_enable_bit
		|=> (matrix_onehot[5] == (16'h1 << $past(second_rank[5].input_select))))
		else $error("enabled output drives the wrong input");

	AST_FROZEN: assert property (@(posedge clk) disable iff (rst)
		($past(pins_sync.update_n) && $past(reset_sync_n) && !$past(rst))
		|=> $stable(applied[7]))
		else $error("outputs moved while update high");
endmodule

// file: hw/xpt_consts.svh
`ifndef XPT_CONSTS_SVH
`define XPT_CONSTS_SVH
`define XPT_NUM_OUTPUTS 8
`define XPT_NUM_INPUTS  16
`define XPT_ADDR_W      3
`define XPT_SEL_W       4
`define XPT_WORD_W      5
`define XPT_EN_POS      4
`define XPT_SEL_LSB     0
`define XPT_SEL_MSB     3
`define XPT_SER_LEN     40
`endif

// file: hw/xpt_pkg.sv
`include "xpt_consts.svh"
package xpt_pkg;
	typedef struct packed {
		logic                      output_enable_bit;
		logic [`XPT_SEL_W-1:0]     input_select;
	} route_word_t;
	typedef struct packed {
		logic                      interface_select;
		logic                      chip_select_n;
		logic                      prog_clk;
		logic                      update_n;
		logic [`XPT_ADDR_W-1:0]    output_addr;
		route_word_t               data;
		logic                      serial_in;
	} prog_pins_t;
endpackage

// file: tb/xpt_host.sv
`timescale 1ns/100ps
module xpt_host
	import xpt_pkg::*;
(
	input  wire logic clk,
	output prog_pins_t pins
);
	// Parallel mode, chip selected, update high, clock high.
	initial pins = prog_pins_t'(13'h1600);
	task automatic hold(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic load(input logic [2:0] a, input route_word_t d);
		pins.output_addr = a;
		pins.data = d;
		hold(4);
		pins.prog_clk = 1'b0;
		hold(4);
		pins.prog_clk = 1'b1;
		hold(4);
		// Lines are no longer held once the latch has closed.
		pins.output_addr = ~a;
		pins.data = ~d;
		hold(4);
	endtask
	// Serial mode: bit 39 first, one falling clock per bit, update kept high.
	task automatic shift(input logic [39:0] bits);
		pins.interface_select = 1'b0;
		for (int i = 39; i >= 0; i--) begin
			pins.serial_in = bits[i];
			hold(4);
			pins.prog_clk = 1'b0;
			hold(4);
			pins.prog_clk = 1'b1;
			hold(4);
		end
		pins.interface_select = 1'b1;
		hold(4);
	endtask
	task automatic update();
		pins.update_n = 1'b0;
		hold(4);
		pins.update_n = 1'b1;
		hold(4);
	endtask
endmodule

// file: tb/tb_crosspoint_parallel_load.sv
`timescale 1ns/100ps
module tb_crosspoint_parallel_load;
	import xpt_pkg::*;
	logic              clk = 1'b0;
	logic              rst = 1'b1;
	logic              reset_pin_n = 1'b0;
	prog_pins_t        pins;
	logic [7:0][15:0]  matrix_onehot;
	route_word_t [7:0] applied;
	logic              serial_out;
	route_word_t [7:0] exp_w = '0;
	int                err_total = 0;
	int                comparisons = 0;
	always #5 clk = ~clk;
	xpt_host host (.clk(clk), .pins(pins));
	crosspoint_parallel_load dut (.clk(clk), .rst(rst), .pins(pins), .reset_pin_n(reset_pin_n),
		.matrix_onehot(matrix_onehot), .applied(applied), .serial_out(serial_out));
	task automatic cmp(input string what, input logic [15:0] got, input logic [15:0] want);
		comparisons++;
		if (got !== want) begin
			err_total++;
			$display("BAD %s expected %h seen %h", what, want, got);
		end
	endtask
	task automatic check_all(input route_word_t [7:0] w);
		for (int i = 0; i < 8; i++) begin
			cmp("applied", {11'h0, applied[i]}, {11'h0, w[i]});
			cmp("matrix", matrix_onehot[i],
				w[i].output_enable_bit ? 16'h1 << w[i].input_select : 16'h0);
		end
	endtask
	task automatic power_up();
		repeat (8) @(posedge clk);
		#1 rst = 1'b0;
		host.hold(6);
		check_all('0);
		reset_pin_n = 1'b1;
		host.hold(4);
	endtask
	// Every output is loaded before the first update.
	task automatic full_load(input int base);
		route_word_t [7:0] prev;
		prev = exp_w;
		for (int i = 0; i < 8; i++) begin
			// Output 3 is loaded with its enable bit clear, so it is the only output left disabled.
			exp_w[i] = route_word_t'({i != 3, 4'(base + i)});
			host.load(3'(i), exp_w[i]);
		end
		check_all(prev);
		host.update();
		check_all(exp_w);
	endtask
	task automatic single_change();
		exp_w[5] = route_word_t'(5'h1f);
		host.load(3'h5, exp_w[5]);
		host.update();
		check_all(exp_w);
	endtask
	task automatic serial_load();
		route_word_t [7:0] prev;
		prev = exp_w;
		for (int i = 0; i < 8; i++) begin
			exp_w[i] = route_word_t'({i != 2 && i != 7, 4'(2 * i + 1)});
		end
		host.shift(exp_w);
		cmp("serial_out", 16'(serial_out), 16'(exp_w[7].output_enable_bit));
		check_all(prev);
		host.update();
		check_all(exp_w);
	endtask
	task automatic reset_mid();
		reset_pin_n = 1'b0;
		host.hold(6);
		check_all('0);
		reset_pin_n = 1'b1;
		host.hold(4);
		host.update();
		check_all(exp_w);
	endtask
	task automatic wrap_up();
		if (err_total == 0 && comparisons > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#100000;
		err_total++;
		wrap_up();
	end
	initial begin
		power_up();
		full_load(0);
		full_load(8);
		single_change();
		serial_load();
		reset_mid();
		wrap_up();
	end
endmodule
